// ---- design/pms_pkg.sv ----
// package: register map, field layout, reset values and mode codes of the power mode switch
package pms_pkg;
  localparam int PMS_ADDR_W = 3;
  localparam int PMS_DATA_W = 8;
  // register offsets
  localparam logic [2:0] PMS_ADDR_SYSCLK_CTRL = 3'h0;
  localparam logic [2:0] PMS_ADDR_FAST_OSC_CTRL = 3'h1;
  localparam logic [2:0] PMS_ADDR_PORTA_WAKE = 3'h2;
  localparam logic [2:0] PMS_ADDR_STATUS = 3'h3;
  localparam logic [2:0] PMS_ADDR_WDT_CTRL = 3'h4;
  localparam logic [2:0] PMS_ADDR_MODE = 3'h5;
  // field positions
  localparam int PMS_CKS_LSB = 5;
  localparam int PMS_FAST_KEEP_BIT = 1;
  localparam int PMS_SLOW_KEEP_BIT = 0;
  localparam int PMS_FAST_STABLE_BIT = 1;
  localparam int PMS_FAST_EN_BIT = 0;
  localparam int PMS_PDF_BIT = 1;
  localparam int PMS_TO_BIT = 0;
  localparam int PMS_WDT_EN_BIT = 0;
  // clock select codes
  localparam logic [2:0] PMS_CKS_SLOW = 3'h7;
  localparam logic [2:0] PMS_CKS_RESET = 3'h0;
  // reset values
  localparam logic PMS_FAST_KEEP_RST = 1'h0;
  localparam logic PMS_SLOW_KEEP_RST = 1'h0;
  localparam logic PMS_FAST_EN_RST = 1'h1;
  localparam logic PMS_WDT_EN_RST = 1'h1;
  localparam logic [7:0] PMS_WAKE_EN_RST = 8'h00;

  // power state, gray coded in the listed order: active, sleep, low, both, high idle
  typedef enum logic [2:0] {
    PMS_ACTIVE = 3'h0,
    PMS_SLEEP = 3'h1,
    PMS_IDLE_LOW = 3'h3,
    PMS_IDLE_BOTH = 3'h2,
    PMS_IDLE_HIGH = 3'h6
  } pms_power_t;

  typedef struct packed {
    logic [PMS_ADDR_W-1:0] addr;
    logic [PMS_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } pms_bus_req_t;

  typedef struct packed {
    logic [2:0] sysClkSelect;
    logic cpuClkRun;
    logic highSpeedClkOn;
    logic lowSpeedSubclkOn;
    logic fastOscEnable;
    logic slowOscEnable;
  } pms_clk_ctrl_t;
endpackage : pms_pkg

// ---- design/pms_mode_ctrl.sv ----
// power mode switch: clock select, halt into sleep/idle, flags, watchdog hooks and wake-up
// Operation
// - writing select 111 in fast mode moves the system clock to the subclock
// - the slow switch completes only once the low-speed oscillator is stable
// - from slow mode, codes 000..110 select high-speed clock divided 1..64
// - halt with both keep bits 0 enters sleep, everything but watchdog stops
// - halt with fast keep 0, slow keep 1 enters low-clock idle
// - halt with both keep bits 1 enters both-clocks idle
// - halt with fast keep 1, slow keep 0 enters high-clock idle
// - in sleep or idle, state is held and execution stops at halt
// - halt sets power-down flag and clears watchdog timeout flag
// - halt clears watchdog counter; it runs on only when enabled
// - low power wakes on enabled port A fall, interrupt or watchdog overflow
// - power-down flag clears only on power-up or clear-watchdog instruction
// - watchdog overflow in low power sets timeout, resets only PC and stack pointer
// - each port A pin has its own wake enable bit
// - pin wake-up resumes at the instruction after halt
// - disabled interrupt or full stack wake resumes after halt, request stays pending
// - enabled interrupt with stack room wakes into normal interrupt response
// - an interrupt already requesting at entry cannot wake the device
// - select 000 undivided, each code doubles division to 110, 111 is subclock
// - enabling the fast oscillator clears its stable flag until it stabilises
// - low-speed oscillator keeps running while the watchdog is enabled
`timescale 1ns/1ps
module pms_mode_ctrl import pms_pkg::*; #(
  parameter int PORT_W = 8,
  parameter int IRQ_W = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire pms_bus_req_t busReq,
  output logic [PMS_DATA_W-1:0] rdData,
  input wire logic haltExec,
  input wire logic clrWdtExec,
  input wire logic [IRQ_W-1:0] irqReq,
  input wire logic [IRQ_W-1:0] irqEnable,
  input wire logic stackFull,
  input wire logic wdtOverflow,
  input wire logic [PORT_W-1:0] portAPin,
  input wire logic fastOscReady,
  input wire logic slowOscReady,
  output pms_clk_ctrl_t clkCtrl,
  output logic cpuHold,
  output logic wdtClear,
  output logic wdtRun,
  output logic resumeAfterHalt,
  output logic irqResponse,
  output logic pcSpReset
);

  // parameters outside what the bus and port fields can carry are refused
  if (PORT_W < 1 || PORT_W > PMS_DATA_W) begin : g_bad_port
    $error("PORT_W must be 1 to 8");
  end
  if (IRQ_W < 1) begin : g_bad_irq
    $error("IRQ_W must be at least 1");
  end

  localparam int SYNC_W = PORT_W + 2;

  // keep bits in the halt cycle pick the low power state
  function automatic pms_power_t halt_target(input logic fastKeep, input logic slowKeep);
    pms_power_t target;
    target = PMS_SLEEP;
    unique case ({fastKeep, slowKeep})
      2'b00: target = PMS_SLEEP;
      2'b01: target = PMS_IDLE_LOW;
      2'b11: target = PMS_IDLE_BOTH;
      2'b10: target = PMS_IDLE_HIGH;
    endcase
    return target;
  endfunction : halt_target

  function automatic logic keeps_fast(input pms_power_t st);
    return (st == PMS_IDLE_BOTH) || (st == PMS_IDLE_HIGH);
  endfunction : keeps_fast

  function automatic logic keeps_slow(input pms_power_t st);
    return (st == PMS_IDLE_BOTH) || (st == PMS_IDLE_LOW);
  endfunction : keeps_slow

  logic [2:0] cksField_reg;
  logic [2:0] actSel_reg;
  logic slowPending_reg;
  logic fastKeep_reg;
  logic slowKeep_reg;
  logic fastEn_reg;
  logic fastStable_reg;
  logic [PORT_W-1:0] wakeEn_reg;
  logic wdtEn_reg;
  logic pdf_reg;
  logic to_reg;
  pms_power_t power_reg;
  pms_power_t power_next;
  logic [IRQ_W-1:0] irqBlocked_reg;
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [SYNC_W-1:0] sync3_reg;
  logic [SYNC_W-1:0] filt_reg;
  logic [PORT_W-1:0] portPrev_reg;
  logic wdtClear_reg;
  logic resume_reg;
  logic irqResp_reg;
  logic pcSp_reg;
  logic [PMS_DATA_W-1:0] rdData_reg;

  logic wrSysClk;
  logic wrFastOsc;
  logic [2:0] wrCks;
  logic slowStable;
  logic fastReadySync;
  logic lowPower;
  logic haltGo;
  logic [PORT_W-1:0] pinFall;
  logic pinWake;
  logic [IRQ_W-1:0] irqNew;
  logic irqWake;
  logic irqServe;

  assign wrSysClk = busReq.wr && (busReq.addr == PMS_ADDR_SYSCLK_CTRL);
  assign wrFastOsc = busReq.wr && (busReq.addr == PMS_ADDR_FAST_OSC_CTRL);
  assign wrCks = busReq.wdata[PMS_CKS_LSB +: 3];
  assign lowPower = (power_reg != PMS_ACTIVE);
  assign haltGo = haltExec && !lowPower;
  assign slowStable = filt_reg[0];
  assign fastReadySync = filt_reg[1];

  // pins and oscillator ready levels cross in through three flops; a level is accepted
  // only when stages two and three agree, which filters a single-cycle glitch
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      filt_reg <= '0;
    end else begin
      sync1_reg <= {portAPin, fastOscReady, slowOscReady};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg <= (sync2_reg & ~(sync2_reg ^ sync3_reg)) | (filt_reg & (sync2_reg ^ sync3_reg));
    end
  end

  // port A falling edges, each gated by its own enable
  always_ff @(posedge clk) begin
    if (!nrst) begin
      portPrev_reg <= '0;
    end else begin
      portPrev_reg <= filt_reg[SYNC_W-1:2];
    end
  end
  assign pinFall = portPrev_reg & ~filt_reg[SYNC_W-1:2] & wakeEn_reg;
  assign pinWake = |pinFall;

  // only requests that were not already up at halt may wake
  assign irqNew = irqReq & ~irqBlocked_reg;
  assign irqWake = |irqNew;
  assign irqServe = |(irqNew & irqEnable) && !stackFull;

  // software side configuration registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cksField_reg <= PMS_CKS_RESET;
      fastKeep_reg <= PMS_FAST_KEEP_RST;
      slowKeep_reg <= PMS_SLOW_KEEP_RST;
      wakeEn_reg <= PORT_W'(PMS_WAKE_EN_RST);
      wdtEn_reg <= PMS_WDT_EN_RST;
    end else if (busReq.wr) begin
      unique case (busReq.addr)
        PMS_ADDR_SYSCLK_CTRL: begin
          cksField_reg <= wrCks;
          fastKeep_reg <= busReq.wdata[PMS_FAST_KEEP_BIT];
          slowKeep_reg <= busReq.wdata[PMS_SLOW_KEEP_BIT];
        end
        PMS_ADDR_PORTA_WAKE: wakeEn_reg <= busReq.wdata[PORT_W-1:0];
        PMS_ADDR_WDT_CTRL: wdtEn_reg <= busReq.wdata[PMS_WDT_EN_BIT];
        default: ;
      endcase
    end
  end

  // applied clock select; the move to the subclock waits for the slow oscillator while
  // the core keeps running on the divided fast clock, so there is never a dead clock
  always_ff @(posedge clk) begin
    if (!nrst) begin
      actSel_reg <= PMS_CKS_RESET;
      slowPending_reg <= 1'b0;
    end else if (wrSysClk && wrCks != PMS_CKS_SLOW) begin
      actSel_reg <= wrCks;
      slowPending_reg <= 1'b0;
    end else if (wrSysClk && actSel_reg != PMS_CKS_SLOW) begin
      slowPending_reg <= 1'b1;
    end else if (slowPending_reg && slowStable) begin
      actSel_reg <= PMS_CKS_SLOW;
      slowPending_reg <= 1'b0;
    end
  end

  // fast oscillator enable and its stable flag; software polls the flag before
  // trusting a fast divided clock after the oscillator was off
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fastEn_reg <= PMS_FAST_EN_RST;
      fastStable_reg <= 1'b0;
    end else begin
      if (wrFastOsc) begin
        fastEn_reg <= busReq.wdata[PMS_FAST_EN_BIT];
      end
      if (wrFastOsc && busReq.wdata[PMS_FAST_EN_BIT] && !fastEn_reg) begin
        fastStable_reg <= 1'b0;
      end else begin
        fastStable_reg <= fastEn_reg && fastReadySync;
      end
    end
  end

  // power state: halt decodes the keep bits of that very cycle, wake returns to active
  always_comb begin
    power_next = power_reg;
    if (haltGo) begin
      power_next = halt_target(fastKeep_reg, slowKeep_reg);
    end else if (lowPower && (wdtOverflow || irqWake || pinWake)) begin
      power_next = PMS_ACTIVE;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      power_reg <= PMS_ACTIVE;
    end else begin
      power_reg <= power_next;
    end
  end

  // snapshot of requests already pending when low power is entered
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irqBlocked_reg <= '0;
    end else if (haltGo) begin
      irqBlocked_reg <= irqReq;
    end else if (!lowPower) begin
      irqBlocked_reg <= '0;
    end
  end

  // status flags; a set in the same cycle as a clear wins
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pdf_reg <= 1'b0;
      to_reg <= 1'b0;
    end else begin
      if (haltGo) begin
        pdf_reg <= 1'b1;
      end else if (clrWdtExec) begin
        pdf_reg <= 1'b0;
      end
      if (wdtOverflow) begin
        to_reg <= 1'b1;
      end else if (haltGo) begin
        to_reg <= 1'b0;
      end
    end
  end

  // one-cycle pulses to the core and watchdog; the wake kind picks where execution goes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wdtClear_reg <= 1'b0;
      resume_reg <= 1'b0;
      irqResp_reg <= 1'b0;
      pcSp_reg <= 1'b0;
    end else begin
      wdtClear_reg <= haltGo || clrWdtExec;
      pcSp_reg <= lowPower && wdtOverflow;
      irqResp_reg <= lowPower && !wdtOverflow && irqWake && irqServe;
      // pin wake and unserviceable interrupt wake both continue after halt
      resume_reg <= lowPower && !wdtOverflow && ((irqWake && !irqServe) ||
                    (!irqWake && pinWake));
    end
  end

  // register read: data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdData_reg <= '0;
    end else if (busReq.rd) begin
      unique case (busReq.addr)
        PMS_ADDR_SYSCLK_CTRL: rdData_reg <= {cksField_reg, 3'h0, fastKeep_reg, slowKeep_reg};
        PMS_ADDR_FAST_OSC_CTRL: rdData_reg <= {6'h00, fastStable_reg, fastEn_reg};
        PMS_ADDR_PORTA_WAKE: rdData_reg <= PMS_DATA_W'(wakeEn_reg);
        PMS_ADDR_STATUS: rdData_reg <= {6'h00, pdf_reg, to_reg};
        PMS_ADDR_WDT_CTRL: rdData_reg <= {7'h00, wdtEn_reg};
        PMS_ADDR_MODE: rdData_reg <= {slowPending_reg, power_reg, 1'b0, actSel_reg};
        default: rdData_reg <= '0;
      endcase
    end else begin
      rdData_reg <= '0;
    end
  end
  assign rdData = rdData_reg;

  // clock gating and oscillator enables; the core freezes so memory, registers and ports
  // hold their state while it is stopped
  assign clkCtrl.sysClkSelect = actSel_reg;
  assign clkCtrl.cpuClkRun = !lowPower;
  assign clkCtrl.fastOscEnable = fastEn_reg && (!lowPower || keeps_fast(power_reg));
  assign clkCtrl.highSpeedClkOn = clkCtrl.fastOscEnable;
  assign clkCtrl.lowSpeedSubclkOn = !lowPower || keeps_slow(power_reg);
  assign clkCtrl.slowOscEnable = clkCtrl.lowSpeedSubclkOn || wdtEn_reg;
  assign cpuHold = lowPower;
  assign wdtClear = wdtClear_reg;
  assign wdtRun = wdtEn_reg;
  assign resumeAfterHalt = resume_reg;
  assign irqResponse = irqResp_reg;
  assign pcSpReset = pcSp_reg;

  // checks
  sequence seq_halt_keep(logic [1:0] keeps);
    haltGo && !busReq.wr && {fastKeep_reg, slowKeep_reg} == keeps;
  endsequence

  sequence seq_quiet_low_power;
    lowPower && !wdtOverflow && !irqWake && !pinWake && !haltExec;
  endsequence

  chk_slow_waits_ready: assert property (@(posedge clk) disable iff (!nrst)
    $changed(actSel_reg) && actSel_reg == PMS_CKS_SLOW && !$past(wrSysClk)
      |-> $past(slowStable))
    else $error("subclock selected before low-speed oscillator stable");

  chk_slow_switch_done: assert property (@(posedge clk) disable iff (!nrst)
    wrSysClk && wrCks == PMS_CKS_SLOW && actSel_reg != PMS_CKS_SLOW && slowStable
      ##1 !wrSysClk |=> actSel_reg == PMS_CKS_SLOW)
    else $error("slow switch did not complete");

  chk_fast_switch_code: assert property (@(posedge clk) disable iff (!nrst)
    wrSysClk && wrCks != PMS_CKS_SLOW |=> actSel_reg == $past(wrCks) && !slowPending_reg)
    else $error("fast divider code not applied");

  chk_halt_sleep: assert property (@(posedge clk) disable iff (!nrst)
    seq_halt_keep(2'b00) |=> power_reg == PMS_SLEEP && !clkCtrl.cpuClkRun
      && !clkCtrl.highSpeedClkOn && !clkCtrl.lowSpeedSubclkOn)
    else $error("halt did not enter sleep");

  chk_halt_idle_low: assert property (@(posedge clk) disable iff (!nrst)
    seq_halt_keep(2'b01) |=> power_reg == PMS_IDLE_LOW && clkCtrl.lowSpeedSubclkOn
      && !clkCtrl.highSpeedClkOn)
    else $error("halt did not enter low-clock idle");

  chk_halt_idle_both: assert property (@(posedge clk) disable iff (!nrst)
    seq_halt_keep(2'b11) |=> power_reg == PMS_IDLE_BOTH && clkCtrl.lowSpeedSubclkOn
      && cpuHold)
    else $error("halt did not enter both-clocks idle");

  chk_halt_idle_high: assert property (@(posedge clk) disable iff (!nrst)
    seq_halt_keep(2'b10) |=> power_reg == PMS_IDLE_HIGH && !clkCtrl.lowSpeedSubclkOn)
    else $error("halt did not enter high-clock idle");

  chk_halt_flags: assert property (@(posedge clk) disable iff (!nrst)
    haltGo && !wdtOverflow |=> pdf_reg && !to_reg && wdtClear)
    else $error("halt flag update wrong");

  chk_pdf_sticky: assert property (@(posedge clk) disable iff (!nrst)
    pdf_reg && !clrWdtExec |=> pdf_reg)
    else $error("power-down flag lost without clear instruction");

  chk_wdt_wake: assert property (@(posedge clk) disable iff (!nrst)
    lowPower && wdtOverflow |=> to_reg && pcSpReset && !resumeAfterHalt && !lowPower
      ##1 !pcSpReset)
    else $error("watchdog wake handling wrong");

  chk_pin_wake: assert property (@(posedge clk) disable iff (!nrst)
    lowPower && pinWake && !irqWake && !wdtOverflow |=> resumeAfterHalt && !lowPower)
    else $error("pin wake did not resume after halt");

  chk_irq_wake_kind: assert property (@(posedge clk) disable iff (!nrst)
    lowPower && irqWake && !wdtOverflow |=> (irqResponse != resumeAfterHalt)
      && irqResponse == $past(irqServe))
    else $error("interrupt wake took the wrong path");

  chk_stays_low: assert property (@(posedge clk) disable iff (!nrst)
    seq_quiet_low_power |=> lowPower && $stable(power_reg))
    else $error("left low power with no wake source");

  chk_stable_clear: assert property (@(posedge clk) disable iff (!nrst)
    wrFastOsc && busReq.wdata[PMS_FAST_EN_BIT] && !fastEn_reg |=> !fastStable_reg)
    else $error("stable flag not cleared on fast oscillator enable");

  chk_low_speed_osc_wdt: assert property (@(posedge clk) disable iff (!nrst)
    wdtEn_reg |-> clkCtrl.slowOscEnable)
    else $error("low-speed oscillator stopped while watchdog enabled");

endmodule : pms_mode_ctrl

// ---- tb/pms_core_model.sv ----
// core-side partner: halt, clear-watchdog, watchdog overflow and interrupt lines
`timescale 1ns/1ps
module pms_core_model (
  input wire logic clk,
  input wire logic irqResponse,
  output logic haltExec,
  output logic clrWdtExec,
  output logic wdtOverflow,
  output logic [3:0] irqReq,
  output logic [3:0] irqEnable,
  output logic stackFull
);
  // quiet core at time zero
  initial begin
    {haltExec, clrWdtExec, wdtOverflow, irqReq, irqEnable, stackFull} = '0;
  end

  // a serviced request is dropped; an unserviced one stays pending until software acts
  always @(posedge clk) begin
    if (irqResponse === 1'h1) begin
      irqReq <= 4'h0;
    end
  end

  // one-cycle pulse: 0 halt, 1 clear watchdog, 2 watchdog overflow
  task automatic pulse(input logic [1:0] sel);
    @(posedge clk);
    haltExec <= (sel == 2'h0);
    clrWdtExec <= (sel == 2'h1);
    wdtOverflow <= (sel == 2'h2);
    @(posedge clk);
    haltExec <= 1'h0;
    clrWdtExec <= 1'h0;
    wdtOverflow <= 1'h0;
    #1;
  endtask : pulse

  // interrupt levels change only right after an edge
  task automatic set_irq(input logic [3:0] req, input logic [3:0] en, input logic full);
    @(posedge clk);
    irqReq <= req;
    irqEnable <= en;
    stackFull <= full;
    #1;
  endtask : set_irq
endmodule : pms_core_model

// ---- tb/pms_mode_ctrl_bench.sv ----
// self-checking bench for the power mode switch
`timescale 1ns/1ps
module pms_mode_ctrl_bench import pms_pkg::*;;
  logic clk;
  logic nrst;
  pms_bus_req_t busReq;
  logic [7:0] rdData;
  logic [7:0] portAPin;
  logic fastOscReady;
  logic slowOscReady;
  pms_clk_ctrl_t clkCtrl;
  logic cpuHold, wdtClear, wdtRun, resumeAfterHalt, irqResponse, pcSpReset;
  logic haltExec, clrWdtExec, wdtOverflow, stackFull;
  logic [3:0] irqReq, irqEnable;
  logic [7:0] rd;
  int nErrors;
  int cmpCount;

  pms_mode_ctrl #(.PORT_W(8), .IRQ_W(4)) DUT (
    .clk(clk), .nrst(nrst), .busReq(busReq), .rdData(rdData), .haltExec(haltExec),
    .clrWdtExec(clrWdtExec), .irqReq(irqReq), .irqEnable(irqEnable),
    .stackFull(stackFull), .wdtOverflow(wdtOverflow), .portAPin(portAPin),
    .fastOscReady(fastOscReady), .slowOscReady(slowOscReady), .clkCtrl(clkCtrl),
    .cpuHold(cpuHold), .wdtClear(wdtClear), .wdtRun(wdtRun),
    .resumeAfterHalt(resumeAfterHalt), .irqResponse(irqResponse), .pcSpReset(pcSpReset)
  );

  pms_core_model core (
    .clk(clk), .irqResponse(irqResponse), .haltExec(haltExec), .clrWdtExec(clrWdtExec),
    .wdtOverflow(wdtOverflow), .irqReq(irqReq), .irqEnable(irqEnable), .stackFull(stackFull)
  );

  // 50 ns clock
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic reportAndStop();
    if (nErrors == 0 && cmpCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : reportAndStop

  task automatic timeout();
    nErrors++;
    $display("BAD %0t wait ran out", $time);
    reportAndStop();
  endtask : timeout

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nErrors++;
      $display("BAD %0t byte got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    cmpCount++;
    if (got !== exp) begin
      nErrors++;
      $display("BAD %0t bit got %b exp %b", $time, got, exp);
    end
  endtask : chk1

  // bus cycles: strobe for one cycle, result looked at just after the taking edge
  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge clk);
    busReq.wr <= 1'h0;
    #1;
  endtask : bus_wr

  task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
    @(posedge clk);
    busReq.rd <= 1'h0;
    #1;
    d = rdData;
  endtask : bus_rd

  task automatic waitn(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : waitn

  // halt with given keep bits; clocks follow the keep bits of that cycle
  task automatic halt_in(input logic [1:0] keep);
    bus_wr(PMS_ADDR_SYSCLK_CTRL, {6'h00, keep});
    core.pulse(2'h0);
    chk1(cpuHold, 1'h1);
    chk1(wdtClear, 1'h1);
    chk1(clkCtrl.highSpeedClkOn, keep[1]);
    chk1(clkCtrl.lowSpeedSubclkOn, keep[0]);
  endtask : halt_in

  // wait for wake, then judge which single pulse came with it
  task automatic woke(input logic pc, input logic irq, input logic res);
    for (int i = 0; i < 30 && cpuHold !== 1'h0; i++) begin
      waitn(1);
    end
    if (cpuHold !== 1'h0) begin
      timeout();
    end
    chk1(pcSpReset, pc);
    chk1(irqResponse, irq);
    chk1(resumeAfterHalt, res);
  endtask : woke

  task automatic t_reset();
    chk1(cpuHold, 1'h0);
    chk1(clkCtrl.cpuClkRun, 1'h1);
    chk1(wdtRun, 1'h1);
    chk8({5'h00, clkCtrl.sysClkSelect}, 8'h00);
    bus_rd(PMS_ADDR_PORTA_WAKE, rd);
    chk8(rd, 8'h00);
    bus_rd(PMS_ADDR_WDT_CTRL, rd);
    chk8(rd, 8'h01);
    bus_wr(PMS_ADDR_STATUS, 8'hFF);
    bus_rd(PMS_ADDR_STATUS, rd);
    chk8(rd, 8'h00);
    bus_rd(3'h6, rd);
    chk8(rd, 8'h00);
  endtask : t_reset

  task automatic t_select();
    bus_wr(PMS_ADDR_SYSCLK_CTRL, 8'hE0);
    waitn(8);
    chk8({5'h00, clkCtrl.sysClkSelect}, 8'h00);
    @(posedge clk);
    slowOscReady <= 1'h1;
    for (int i = 0; i < 12 && clkCtrl.sysClkSelect !== PMS_CKS_SLOW; i++) begin
      waitn(1);
    end
    chk8({5'h00, clkCtrl.sysClkSelect}, 8'h07);
    // every fast code is entered from slow mode
    for (int c = 0; c < 7; c++) begin
      bus_wr(PMS_ADDR_SYSCLK_CTRL, {c[2:0], 5'h00});
      waitn(1);
      chk8({5'h00, clkCtrl.sysClkSelect}, 8'(c));
      bus_wr(PMS_ADDR_SYSCLK_CTRL, 8'hE0);
      waitn(3);
      chk8({5'h00, clkCtrl.sysClkSelect}, 8'h07);
    end
  endtask : t_select

  task automatic t_fast();
    @(posedge clk);
    fastOscReady <= 1'h0;
    bus_wr(PMS_ADDR_FAST_OSC_CTRL, 8'h00);
    chk1(clkCtrl.fastOscEnable, 1'h0);
    waitn(6);
    bus_wr(PMS_ADDR_FAST_OSC_CTRL, 8'h01);
    bus_rd(PMS_ADDR_FAST_OSC_CTRL, rd);
    chk8(rd & 8'h03, 8'h01);
    @(posedge clk);
    fastOscReady <= 1'h1;
    // software polls the stable flag before trusting the fast clock
    for (int i = 0; i < 20 && rd[1] !== 1'h1; i++) begin
      bus_rd(PMS_ADDR_FAST_OSC_CTRL, rd);
    end
    chk8(rd & 8'h03, 8'h03);
  endtask : t_fast

  task automatic t_modes();
    for (int k = 0; k < 4; k++) begin
      halt_in(k[1:0]);
      chk1(clkCtrl.slowOscEnable, 1'h1);
      bus_rd(PMS_ADDR_STATUS, rd);
      chk8(rd, 8'h02);
      bus_wr(PMS_ADDR_SYSCLK_CTRL, {6'h00, ~k[1:0]});
      chk1(clkCtrl.highSpeedClkOn, k[1]);
      chk1(clkCtrl.lowSpeedSubclkOn, k[0]);
      core.pulse(2'h2);
      woke(1'h1, 1'h0, 1'h0);
      bus_rd(PMS_ADDR_STATUS, rd);
      chk8(rd, 8'h03);
    end
  endtask : t_modes

  task automatic t_wake();
    bus_wr(PMS_ADDR_PORTA_WAKE, 8'h04);
    halt_in(2'h1);
    core.set_irq(4'h2, 4'h2, 1'h0);
    woke(1'h0, 1'h1, 1'h0);
    halt_in(2'h1);
    core.set_irq(4'h2, 4'h0, 1'h0);
    woke(1'h0, 1'h0, 1'h1);
    core.set_irq(4'h0, 4'h0, 1'h0);
    halt_in(2'h1);
    core.set_irq(4'h2, 4'h2, 1'h1);
    woke(1'h0, 1'h0, 1'h1);
    core.set_irq(4'h0, 4'h0, 1'h0);
    // only the pin whose wake bit is set may wake
    halt_in(2'h1);
    bus_rd(PMS_ADDR_PORTA_WAKE, rd);
    chk8(rd, 8'h04);
    portAPin <= 8'hF7;
    waitn(12);
    chk1(cpuHold, 1'h1);
    portAPin <= 8'hF3;
    woke(1'h0, 1'h0, 1'h1);
    portAPin <= 8'hFF;
    // a request already pending at entry cannot wake
    core.set_irq(4'h1, 4'h1, 1'h0);
    halt_in(2'h1);
    waitn(12);
    chk1(cpuHold, 1'h1);
    core.pulse(2'h2);
    woke(1'h1, 1'h0, 1'h0);
    core.set_irq(4'h0, 4'h0, 1'h0);
  endtask : t_wake

  task automatic t_flags();
    core.pulse(2'h1);
    bus_rd(PMS_ADDR_STATUS, rd);
    chk8(rd, 8'h01);
    bus_wr(PMS_ADDR_WDT_CTRL, 8'h00);
    chk1(wdtRun, 1'h0);
    halt_in(2'h0);
    chk1(clkCtrl.slowOscEnable, 1'h0);
    chk1(clkCtrl.cpuClkRun, 1'h0);
    portAPin <= 8'hFB;
    woke(1'h0, 1'h0, 1'h1);
    portAPin <= 8'hFF;
    bus_wr(PMS_ADDR_WDT_CTRL, 8'h01);
    chk1(wdtRun, 1'h1);
  endtask : t_flags

  // reset for four cycles, then the scenarios in turn
  initial begin
    nErrors = 0;
    cmpCount = 0;
    nrst = 1'h0;
    busReq = '0;
    portAPin = 8'hFF;
    fastOscReady = 1'h1;
    slowOscReady = 1'h0;
    repeat (4) @(posedge clk);
    nrst <= 1'h1;
    waitn(1);
    t_reset();
    t_select();
    t_fast();
    t_modes();
    t_wake();
    t_flags();
    reportAndStop();
  end
endmodule : pms_mode_ctrl_bench
